// file: rtl/bie_decode.sv
`timescale 1ns/1ps
`include "bie_params.svh"

// ==========================================
// opcode classification
module bie_decode (
    // instruction word
    input wire bie_pkg::bie_word_t instrWord,
    // decoded class
    output bie_pkg::bie_op_e opClass
);
    import bie_pkg::*;

    // pattern match on the opcode bits only
    always_comb begin
        if ((instrWord & `BIE_OP_JUMP_MASK) == `BIE_OP_JUMP_VAL) begin
            opClass = BIE_OP_JUMP;
        end else if ((instrWord & `BIE_OP_INC_MASK) == `BIE_OP_INCSKIP_VAL) begin
            opClass = BIE_OP_INCSKIP;
        end else if ((instrWord & `BIE_OP_INC_MASK) == `BIE_OP_INCREG_VAL) begin
            opClass = BIE_OP_INCREG;
        end else begin
            opClass = BIE_OP_NONE;
        end
    end
endmodule : bie_decode

// file: rtl/bie_exec.sv
// Operation
// - A jump loads its 11-bit immediate into program counter bits 10 to 0.
// - A jump copies upper page latch bits 4 and 3 into program counter bits 12 and 11.
// - A jump is one word and takes two instruction cycles.
// - Increment-and-skip adds one to the register and writes accumulator or register by d.
// - A zero increment-and-skip result discards the already fetched next instruction.
// - The discarded slot runs as a no-operation, so the skip costs two cycles.
// - Plain increment adds one in one cycle and stores by the destination bit.
`timescale 1ns/1ps
`include "bie_params.svh"

module bie_exec (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // instruction issue from fetch
    input wire logic instrValid,
    input wire bie_pkg::bie_word_t instrWord,
    // machine state from the core
    input wire logic [7:0] upperPageLatch,
    input wire logic [7:0] fileReadData,
    input wire logic zeroFlagIn,
    // file register access (address is combinational from the word)
    output logic [6:0] fileAddr,
    // results, all registered
    output logic pcLoad,
    output bie_pkg::bie_pc_t pcValue,
    output logic accWrite,
    output logic fileWrite,
    output logic [6:0] fileWriteAddr,
    output logic [7:0] resultData,
    output logic zeroWrite,
    output logic zeroFlagOut,
    output logic flushFetch,
    output logic busy
);
    import bie_pkg::*;

    // the file address leaves combinationally so the read returns this cycle
    assign fileAddr = instrWord[6:0];

    bie_op_e opClass;
    bie_decode u_decode (
        .instrWord(instrWord),
        .opClass(opClass)
    );

    // ==========================================
    // sequencing state
    typedef enum logic [1:0] {
        BIE_ST_ISSUE,
        BIE_ST_JUMP_WAIT,
        BIE_ST_NOP_SLOT
    } bie_state_e;

    bie_state_e state_ff, nxt_state;
    logic pcLoad_ff, nxt_pcLoad;
    bie_pc_t pcValue_ff, nxt_pcValue;
    logic accWrite_ff, nxt_accWrite;
    logic fileWrite_ff, nxt_fileWrite;
    logic [6:0] fileWriteAddr_ff, nxt_fileWriteAddr;
    logic [7:0] resultData_ff, nxt_resultData;
    logic zeroWrite_ff, nxt_zeroWrite;
    logic zeroFlag_ff, nxt_zeroFlag;
    logic flush_ff, nxt_flush;
    logic busy_ff, nxt_busy;
    logic [7:0] incResult;
    logic toFile;

    // 8-bit add wraps naturally from 0xFF to 0x00
    assign incResult = fileReadData + 8'h01;
    assign toFile = instrWord[`BIE_DEST_BIT];

    // next-state and result computation
    always_comb begin
        nxt_state = state_ff;
        nxt_pcLoad = 1'b0;
        nxt_pcValue = pcValue_ff;
        nxt_accWrite = 1'b0;
        nxt_fileWrite = 1'b0;
        nxt_fileWriteAddr = fileWriteAddr_ff;
        nxt_resultData = resultData_ff;
        nxt_zeroWrite = 1'b0;
        nxt_zeroFlag = zeroFlag_ff;
        nxt_flush = 1'b0;
        nxt_busy = 1'b0;
        unique case (state_ff)
            BIE_ST_ISSUE: begin
                if (instrValid) begin
                    unique case (opClass)
                        BIE_OP_JUMP: begin
                            nxt_pcValue[10:0] = instrWord[10:0];
                            nxt_pcValue[12:11] =
                                upperPageLatch[`BIE_LATCH_HI:`BIE_LATCH_LO];
                            nxt_pcLoad = 1'b1;
                            nxt_flush = 1'b1;
                            nxt_busy = 1'b1;
                            nxt_state = BIE_ST_JUMP_WAIT;
                        end
                        BIE_OP_INCSKIP: begin
                            nxt_resultData = incResult;
                            nxt_fileWriteAddr = instrWord[6:0];
                            nxt_fileWrite = toFile;
                            nxt_accWrite = !toFile;
                            if (incResult == 8'h00) begin
                                nxt_flush = 1'b1;
                                nxt_busy = 1'b1;
                                nxt_state = BIE_ST_NOP_SLOT;
                            end
                        end
                        BIE_OP_INCREG: begin
                            nxt_resultData = incResult;
                            nxt_fileWriteAddr = instrWord[6:0];
                            nxt_fileWrite = toFile;
                            nxt_accWrite = !toFile;
                            nxt_zeroWrite = 1'b1;
                            nxt_zeroFlag = (incResult == 8'h00);
                        end
                        BIE_OP_NONE: begin
                            // other instructions belong to other units
                            nxt_zeroFlag = zeroFlagIn;
                        end
                    endcase
                end
            end
            BIE_ST_JUMP_WAIT: begin
                // fetch refills from the new target during this slot
                nxt_state = BIE_ST_ISSUE;
            end
            BIE_ST_NOP_SLOT: begin
                nxt_state = BIE_ST_ISSUE;
            end
        endcase
    end

    // register stage
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= BIE_ST_ISSUE;
            pcLoad_ff <= 1'b0;
            pcValue_ff <= 13'h0_000;
            accWrite_ff <= 1'b0;
            fileWrite_ff <= 1'b0;
            fileWriteAddr_ff <= 7'h00;
            resultData_ff <= 8'h00;
            zeroWrite_ff <= 1'b0;
            zeroFlag_ff <= 1'b0;
            flush_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pcLoad_ff <= nxt_pcLoad;
            pcValue_ff <= nxt_pcValue;
            accWrite_ff <= nxt_accWrite;
            fileWrite_ff <= nxt_fileWrite;
            fileWriteAddr_ff <= nxt_fileWriteAddr;
            resultData_ff <= nxt_resultData;
            zeroWrite_ff <= nxt_zeroWrite;
            zeroFlag_ff <= nxt_zeroFlag;
            flush_ff <= nxt_flush;
            busy_ff <= nxt_busy;
        end
    end

    assign pcLoad = pcLoad_ff;
    assign pcValue = pcValue_ff;
    assign accWrite = accWrite_ff;
    assign fileWrite = fileWrite_ff;
    assign fileWriteAddr = fileWriteAddr_ff;
    assign resultData = resultData_ff;
    assign zeroWrite = zeroWrite_ff;
    assign zeroFlagOut = zeroFlag_ff;
    assign flushFetch = flush_ff;
    assign busy = busy_ff;

    // ==========================================
    // assertions
    wire issueJump = instrValid && state_ff == BIE_ST_ISSUE && opClass == BIE_OP_JUMP;
    wire issueSkip = instrValid && state_ff == BIE_ST_ISSUE && opClass == BIE_OP_INCSKIP;
    wire issueInc = instrValid && state_ff == BIE_ST_ISSUE && opClass == BIE_OP_INCREG;

    sequence s_jumpTaken;
        issueJump ##1 (pcLoad && flushFetch && busy);
    endsequence

    a_jump_low_bits: assert property (@(posedge clk) disable iff (reset)
        issueJump |=> pcValue[10:0] == $past(instrWord[10:0]))
        else $error("jump low bits wrong");
    a_jump_page_bits: assert property (@(posedge clk) disable iff (reset)
        issueJump |=> pcValue[12:11] == $past(upperPageLatch[4:3]))
        else $error("jump page bits wrong");
    a_jump_two_cycles: assert property (@(posedge clk) disable iff (reset)
        issueJump |-> s_jumpTaken ##1 (state_ff == BIE_ST_ISSUE && !pcLoad))
        else $error("jump not two cycles");
    a_skip_dest_write: assert property (@(posedge clk) disable iff (reset)
        issueSkip |=> (fileWrite == $past(instrWord[7])) && (accWrite != fileWrite)
            && resultData == $past(fileReadData) + 8'h01)
        else $error("skip increment result wrong");
    a_skip_flush_zero: assert property (@(posedge clk) disable iff (reset)
        issueSkip |=> flushFetch == ($past(fileReadData) == 8'hFF))
        else $error("skip flush mismatch");
    a_skip_nop_slot: assert property (@(posedge clk) disable iff (reset)
        (issueSkip && fileReadData == 8'hFF) |=> busy ##1 !busy && !accWrite && !fileWrite)
        else $error("skip nop slot wrong");
    a_inc_single: assert property (@(posedge clk) disable iff (reset)
        issueInc |=> !busy && !flushFetch && (accWrite || fileWrite))
        else $error("increment not single cycle");
    a_inc_zero_flag: assert property (@(posedge clk) disable iff (reset)
        issueInc |=> zeroWrite && zeroFlagOut == ($past(fileReadData) == 8'hFF))
        else $error("increment zero flag wrong");
    a_flags_kept: assert property (@(posedge clk) disable iff (reset)
        (issueJump || issueSkip) |=> !zeroWrite)
        else $error("flags touched");
endmodule : bie_exec

// file: rtl/bie_params.svh
`ifndef BIE_PARAMS_SVH
`define BIE_PARAMS_SVH

// ==========================================
// opcode patterns and field positions
`define BIE_OP_JUMP_MASK 14'h3_800
`define BIE_OP_JUMP_VAL 14'h2_800
`define BIE_OP_INC_MASK 14'h3_F00
`define BIE_OP_INCSKIP_VAL 14'h0_F00
`define BIE_OP_INCREG_VAL 14'h0_A00
`define BIE_DEST_BIT 7
`define BIE_LATCH_HI 4
`define BIE_LATCH_LO 3
`define BIE_JUMP_CYCLES 2
`define BIE_NOP_WORD 14'h0_000

`endif

// file: rtl/bie_pkg.sv
package bie_pkg;
    typedef enum logic [1:0] {
        BIE_OP_NONE,
        BIE_OP_JUMP,
        BIE_OP_INCSKIP,
        BIE_OP_INCREG
    } bie_op_e;
    typedef logic [13:0] bie_word_t;
    typedef logic [12:0] bie_pc_t;
endpackage : bie_pkg

// file: test/tb_branch_and_increment_exec.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the jump and increment executor
module tb_branch_and_increment_exec;
    import bie_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic instrValid = 1'b0;
    bie_word_t instrWord = 14'h0_000;
    logic [7:0] upperPageLatch = 8'h00;
    logic [7:0] fileReadData = 8'h00;
    logic zeroFlagIn = 1'b0;
    logic [6:0] fileAddr, fileWriteAddr;
    logic pcLoad, accWrite, fileWrite, zeroWrite, zeroFlagOut, flushFetch, busy;
    bie_pc_t pcValue;
    logic [7:0] resultData;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    integer seed = 32'hdc59_7e43;
    logic [31:0] r;
    bie_word_t rndWord;
    // pulse outputs in the order {pcLoad,accWrite,fileWrite,zeroWrite,flushFetch,busy}
    wire [5:0] outPulse = {pcLoad, accWrite, fileWrite, zeroWrite, flushFetch, busy};
    // what the last rising edge should have launched: 0 none, 1 quiet slot, 2 issue result
    logic [1:0] pendMode = 2'd0;
    logic [5:0] pendPulse = 6'h00;
    bie_word_t pendWord = 14'h0_000;
    logic [7:0] pendLat = 8'h00;
    logic [7:0] pendRes = 8'h00;
    logic pendZin = 1'b0;

    bie_exec bie_exec_inst (.clk(clk), .reset(reset), .instrValid(instrValid),
        .instrWord(instrWord), .upperPageLatch(upperPageLatch), .fileReadData(fileReadData),
        .zeroFlagIn(zeroFlagIn), .fileAddr(fileAddr), .pcLoad(pcLoad), .pcValue(pcValue),
        .accWrite(accWrite), .fileWrite(fileWrite), .fileWriteAddr(fileWriteAddr),
        .resultData(resultData), .zeroWrite(zeroWrite), .zeroFlagOut(zeroFlagOut),
        .flushFetch(flushFetch), .busy(busy));

    // ==========================================
    // clock, hang guard and closing report
    always #25 clk = ~clk;
    // ceiling is several times the cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // ==========================================
    // expected pulses {pcLoad,accWrite,fileWrite,zeroWrite,flushFetch,busy}
    function automatic logic [5:0] exp_pulses(input bie_word_t w, input logic [7:0] d);
        logic [7:0] res;
        res = d + 8'h01;
        if ((w & 14'h3_800) == 14'h2_800)
            return 6'b10_0011;
        if ((w & 14'h3_F00) == 14'h0_F00)
            return {1'b0, ~w[7], w[7], 1'b0, res == 8'h00, res == 8'h00};
        if ((w & 14'h3_F00) == 14'h0_A00)
            return {1'b0, ~w[7], w[7], 1'b1, 2'b00};
        return 6'b00_0000;
    endfunction : exp_pulses

    // compare what the last rising edge launched, called at the falling edge after it
    task check_prev();
        if (pendMode != 2'd0)
            chk(16'(outPulse), 16'(pendPulse));
        if (pendMode == 2'd2) begin
            if (pendPulse[5])
                chk(16'(pcValue), 16'({pendLat[4:3], pendWord[10:0]}));
            if (pendPulse[4] | pendPulse[3]) begin
                chk(16'(resultData), 16'(pendRes));
                chk(16'(fileWriteAddr), 16'(pendWord[6:0]));
            end
            if (pendPulse[2])
                chk(16'(zeroFlagOut), 16'(pendRes == 8'h00));
            // words owned elsewhere pass the core's zero flag through untouched
            if (pendPulse == 6'h00)
                chk(16'(zeroFlagOut), 16'(pendZin));
        end
        pendMode = 2'd0;
    endtask : check_prev

    // issue one word: entered in the time step of a rising edge, inputs change by nba there;
    // returns at the edge on which the next word may be driven, so single-cycle ops go
    // back to back; hold keeps valid up through a busy slot, which must ignore it
    task run_op(input bie_word_t w, input logic [7:0] lat, input logic [7:0] d,
                input logic zin, input logic hold);
        instrValid <= 1'b1;
        instrWord <= w;
        upperPageLatch <= lat;
        fileReadData <= d;
        zeroFlagIn <= zin;
        @(negedge clk);
        check_prev();
        chk(16'(fileAddr), 16'(w[6:0]));
        pendMode = 2'd2;
        pendPulse = exp_pulses(w, d);
        pendWord = w;
        pendLat = lat;
        pendRes = d + 8'h01;
        pendZin = zin;
        @(posedge clk);
        // two-cycle ops: the second cycle is a quiet no-operation slot
        if (pendPulse[0]) begin
            instrValid <= hold;
            @(negedge clk);
            check_prev();
            pendMode = 2'd1;
            pendPulse = 6'h00;
            @(posedge clk);
        end
    endtask : run_op

    // ==========================================
    // main sequence: corners first, then random traffic
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // the release edge still sees reset, so everything it launches is low
        pendMode = 2'd1;
        pendPulse = 6'h00;
        // jump range ends, first with both page bits set, then with both clear
        run_op(14'h2_800, 8'h18, 8'h00, 1'b0, 1'b0);
        run_op(14'h2_FFF, 8'hE7, 8'h00, 1'b1, 1'b1);
        // skip on zero and non-zero, both destinations, back to back
        run_op(14'h0_F7F, 8'h00, 8'hFF, 1'b0, 1'b1);
        run_op(14'h0_F80, 8'h00, 8'hFF, 1'b1, 1'b0);
        run_op(14'h0_FAA, 8'h00, 8'h00, 1'b0, 1'b0);
        // plain increment wrap and non-zero
        run_op(14'h0_AFF, 8'h00, 8'hFF, 1'b0, 1'b0);
        run_op(14'h0_A05, 8'h00, 8'h7F, 1'b1, 1'b0);
        // neighbours that this block does not own
        run_op(14'h0_B00, 8'h00, 8'h01, 1'b0, 1'b0);
        run_op(14'h2_7FF, 8'h18, 8'hFF, 1'b0, 1'b0);
        run_op(14'h3_800, 8'h18, 8'hFF, 1'b0, 1'b0);
        // random mix of all classes, 0xFF data often to force skips
        for (int i = 0; i < 300; i++) begin
            r = $random(seed);
            case (r[17:16])
                2'd0: rndWord = 14'h2_800 | 14'(r[10:0]);
                2'd1: rndWord = 14'h0_F00 | 14'(r[7:0]);
                2'd2: rndWord = 14'h0_A00 | 14'(r[7:0]);
                default: rndWord = r[13:0];
            endcase
            run_op(rndWord, r[31:24], r[19:18] == 2'd0 ? 8'hFF : r[27:20], r[21], r[22]);
        end
        // drop valid and collect the last launched result
        instrValid <= 1'b0;
        @(negedge clk);
        check_prev();
        wrap_up();
    end
endmodule : tb_branch_and_increment_exec
